// ===== dci_debug_cmd.sv
// Debug command interpreter with its response FIFO.
// Assumes byte-level rx/tx handshakes to a pin serialiser, synchronous to clk.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Response FIFO: flip-flop storage, valid/ready on both sides
module dci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Refuse shapes the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("dci_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage
  logic [AW-1:0] wr_q;  // Write index
  logic [AW-1:0] rd_q;  // Read index
  logic [AW:0] cnt_q;  // Fill level
  logic push, pop;  // Handshakes taken on each side
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Storage write, no reset needed on data
  always_ff @(posedge clk)
    if (push)
      mem_q[wr_q] <= in_data;
  // Pointers and level
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      // Push and pop in one cycle leave the level as it was
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule // dci_fifo
////////////////////////////////////////////////////////////////////////////////
// How it works
// - 03H returns run counter, high byte first
// - 04H stores next byte in control register
// - Protected: halt flag settable, never cleared
// - 05H returns control register byte
// - 06H loads PC unless gated off
// - 07H returns PC, FFFFH when gated
// - 08H takes address high, low, size, data
// - 1 to 256 bytes, zero size means 256
// - Outside debug mode register writes discarded
// - Protected: only flash control writes land
// - Option bit zero means read protection
module dci_debug_cmd #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_valid,
  output logic rx_ready_q,
  input wire logic [7:0] rx_data,
  output logic tx_valid_q,
  input wire logic tx_ready,
  output logic [7:0] tx_data_q,
  input wire logic [15:0] run_cycle_counter,
  input wire logic read_protect_option,
  input wire logic [15:0] instruction_pointer,
  output logic [7:0] debugger_control_reg,
  output logic halt_for_debug_flag,
  output logic pc_wr_q,
  output logic [15:0] pc_data_q,
  output logic rf_we_q,
  output dci_pkg::dci_rf_wr_t rf_wr_q
);
  dci_pkg::dci_state_t st_q;  // Sequencer state
  dci_pkg::dci_state_t st_d;
  logic [7:0] ctl_q;  // Debugger control register
  logic [15:0] resp_q;  // Pending response word
  logic [8:0] cnt_q;  // Data bytes left in a write
  logic [11:0] adr_q;  // Register write address
  logic [7:0] pch_q;  // Held PC high byte
  logic fire, prot, dbg;  // Byte taken, protection in force, debug mode
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;  // Response FIFO handshakes
  logic [7:0] f_in_data, f_out_data;  // Response FIFO bytes
  // Address in the flash control window
  function automatic logic in_flash(input logic [11:0] a);
    in_flash = (a >= dci_pkg::FLASH_CTL_LO) && (a <= dci_pkg::FLASH_CTL_HI);
  endfunction
  assign fire = rx_valid && rx_ready_q;
  assign prot = (read_protect_option == dci_pkg::PROT_ACTIVE);
  assign dbg = ctl_q[dci_pkg::HALT_BIT];
  assign debugger_control_reg = ctl_q;
  assign halt_for_debug_flag = ctl_q[dci_pkg::HALT_BIT];
  // FIFO fill side stalls the transmit states
  assign f_in_valid = (st_q == dci_pkg::ST_TX_HI) || (st_q == dci_pkg::ST_TX_LO);
  assign f_in_data = (st_q == dci_pkg::ST_TX_HI) ? resp_q[15:8] : resp_q[7:0];
  assign f_out_ready = !tx_valid_q || tx_ready;
  //////////////////////////////////////////////////////////////////////////////
  // Next state: decode command, walk operands, then responses
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      dci_pkg::ST_IDLE:
        if (fire)
          // Unknown codes are swallowed and idle again
          case (rx_data)
            dci_pkg::CMD_RD_CNT: st_d = dci_pkg::ST_TX_HI;
            dci_pkg::CMD_WR_CTL: st_d = dci_pkg::ST_CTL;
            dci_pkg::CMD_RD_CTL: st_d = dci_pkg::ST_TX_LO;
            dci_pkg::CMD_WR_PC: st_d = dci_pkg::ST_PC_HI;
            dci_pkg::CMD_RD_PC: st_d = dci_pkg::ST_TX_HI;
            dci_pkg::CMD_WR_REG: st_d = dci_pkg::ST_ADR_HI;
            default: st_d = dci_pkg::ST_IDLE;
          endcase
      dci_pkg::ST_CTL: if (fire) st_d = dci_pkg::ST_IDLE;
      dci_pkg::ST_PC_HI: if (fire) st_d = dci_pkg::ST_PC_LO;
      dci_pkg::ST_PC_LO: if (fire) st_d = dci_pkg::ST_IDLE;
      dci_pkg::ST_ADR_HI: if (fire) st_d = dci_pkg::ST_ADR_LO;
      dci_pkg::ST_ADR_LO: if (fire) st_d = dci_pkg::ST_SIZE;
      dci_pkg::ST_SIZE: if (fire) st_d = dci_pkg::ST_DATA;
      dci_pkg::ST_DATA: if (fire && cnt_q == 9'h001) st_d = dci_pkg::ST_IDLE;
      dci_pkg::ST_TX_HI: if (f_in_ready) st_d = dci_pkg::ST_TX_LO;
      dci_pkg::ST_TX_LO: if (f_in_ready) st_d = dci_pkg::ST_IDLE;
      default: st_d = dci_pkg::ST_IDLE;
    endcase
  end
  // State and host-side ready; no bytes taken while answering
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      st_q <= dci_pkg::ST_IDLE;
      rx_ready_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      rx_ready_q <= (st_d != dci_pkg::ST_TX_HI) && (st_d != dci_pkg::ST_TX_LO);
    end
  // Control register; under protection the halt flag only sets
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ctl_q <= dci_pkg::CTL_RESET;
    else if (st_q == dci_pkg::ST_CTL && fire)
    begin
      ctl_q <= rx_data;
      if (prot)
        ctl_q[dci_pkg::HALT_BIT] <= ctl_q[dci_pkg::HALT_BIT] | rx_data[dci_pkg::HALT_BIT];
    end
  // Response capture at decode; values snapshot at the command
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      resp_q <= '0;
    else if (st_q == dci_pkg::ST_IDLE && fire)
    begin
      if (rx_data == dci_pkg::CMD_RD_CNT)
        resp_q <= run_cycle_counter;
      else if (rx_data == dci_pkg::CMD_RD_CTL)
        resp_q <= {8'h00, ctl_q};
      else if (rx_data == dci_pkg::CMD_RD_PC)
        resp_q <= (dbg && !prot) ? instruction_pointer : dci_pkg::PC_BLOCKED;
    end
  // Program counter load, dropped outside debug or under protection
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pch_q <= '0;
      pc_wr_q <= 1'b0;
      pc_data_q <= '0;
    end
    else
    begin
      pc_wr_q <= 1'b0;
      if (st_q == dci_pkg::ST_PC_HI && fire)
        pch_q <= rx_data;
      if (st_q == dci_pkg::ST_PC_LO && fire && dbg && !prot)
      begin
        pc_wr_q <= 1'b1;
        pc_data_q <= {pch_q, rx_data};
      end
    end
  end
  // Register file write: address, size, then gated data bytes
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      adr_q <= '0;
      cnt_q <= '0;
      rf_we_q <= 1'b0;
      rf_wr_q <= '0;
    end
    else
    begin
      rf_we_q <= 1'b0;
      if (st_q == dci_pkg::ST_ADR_HI && fire)
        adr_q[11:8] <= rx_data[3:0];
      if (st_q == dci_pkg::ST_ADR_LO && fire)
        adr_q[7:0] <= rx_data;
      if (st_q == dci_pkg::ST_SIZE && fire)
        cnt_q <= (rx_data == dci_pkg::SIZE_ZERO) ? dci_pkg::SIZE_MAX : {1'b0, rx_data};
      if (st_q == dci_pkg::ST_DATA && fire)
      begin
        cnt_q <= cnt_q - 9'h001;
        adr_q <= adr_q + 12'h001;
        // Bytes always consumed; only the strobe and write word are gated
        if (dbg && (!prot || in_flash(adr_q)))
        begin
          rf_we_q <= 1'b1;
          rf_wr_q <= '{addr: adr_q, data: rx_data};
        end
      end
    end
  end
  // Output stage so tx pins come straight from flops
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      tx_valid_q <= 1'b0;
      tx_data_q <= '0;
    end
    else if (f_out_ready)
    begin
      tx_valid_q <= f_out_valid;
      tx_data_q <= f_out_data;
    end
  dci_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .rstn(rstn),
    .in_valid(f_in_valid), .in_ready(f_in_ready), .in_data(f_in_data),
    .out_valid(f_out_valid), .out_ready(f_out_ready), .out_data(f_out_data)
  );
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_cmd(logic [7:0] c);
    st_q == dci_pkg::ST_IDLE && fire && rx_data == c;
  endsequence
  sequence s_last_push;
    st_q == dci_pkg::ST_TX_LO && f_in_ready;
  endsequence
  property p_rd_cnt;
    s_cmd(dci_pkg::CMD_RD_CNT) |=> st_q == dci_pkg::ST_TX_HI
      && resp_q == $past(run_cycle_counter) ##1 st_q == dci_pkg::ST_TX_LO || !$past(f_in_ready);
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) else $error("count read wrong");
  property p_wr_ctl;
    st_q == dci_pkg::ST_CTL && fire && !prot |=> ctl_q == $past(rx_data);
  endproperty
  a_wr_ctl: assert property (p_wr_ctl) else $error("control write lost");
  property p_halt_keep;
    prot && ctl_q[dci_pkg::HALT_BIT] |=> ctl_q[dci_pkg::HALT_BIT];
  endproperty
  a_halt_keep: assert property (p_halt_keep) else $error("halt flag cleared");
  property p_rd_ctl;
    s_cmd(dci_pkg::CMD_RD_CTL) |=> st_q == dci_pkg::ST_TX_LO && resp_q[7:0] == $past(ctl_q);
  endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read wrong");
  property p_pc_gate;
    pc_wr_q |-> $past(dbg) && !$past(prot) && pc_data_q[7:0] == $past(rx_data);
  endproperty
  a_pc_gate: assert property (p_pc_gate) else $error("pc load not gated");
  property p_pc_blk;
    s_cmd(dci_pkg::CMD_RD_PC) ##0 (prot || !dbg) |=> resp_q == dci_pkg::PC_BLOCKED;
  endproperty
  a_pc_blk: assert property (p_pc_blk) else $error("pc read not blocked");
  property p_size0;
    st_q == dci_pkg::ST_SIZE && fire && rx_data == dci_pkg::SIZE_ZERO |=> cnt_q == dci_pkg::SIZE_MAX;
  endproperty
  a_size0: assert property (p_size0) else $error("size zero not 256");
  property p_rf_gate;
    rf_we_q |-> $past(dbg) && (!$past(prot) || in_flash(rf_wr_q.addr));
  endproperty
  a_rf_gate: assert property (p_rf_gate) else $error("register write not gated");
  property p_idle_after;
    s_last_push |=> st_q == dci_pkg::ST_IDLE && rx_ready_q;
  endproperty
  a_idle_after: assert property (p_idle_after) else $error("no return to idle");
endmodule // dci_debug_cmd

// ===== dci_pkg.sv
// Shared constants and types for the debug command interpreter.
// Assumes a byte-level link: a serialiser outside delivers whole bytes.
package dci_pkg;
  // Command codes
  localparam logic [7:0] CMD_RD_CNT = 8'h03;
  localparam logic [7:0] CMD_WR_CTL = 8'h04;
  localparam logic [7:0] CMD_RD_CTL = 8'h05;
  localparam logic [7:0] CMD_WR_PC = 8'h06;
  localparam logic [7:0] CMD_RD_PC = 8'h07;
  localparam logic [7:0] CMD_WR_REG = 8'h08;
  // Field positions and values
  localparam int HALT_BIT = 7;
  localparam logic PROT_ACTIVE = 1'b0;
  localparam logic [15:0] PC_BLOCKED = 16'hFFFF;
  localparam logic [8:0] SIZE_MAX = 9'h100;
  localparam logic [7:0] SIZE_ZERO = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  // Flash control register window (12-bit register file addresses)
  localparam logic [11:0] FLASH_CTL_LO = 12'hFF8;
  localparam logic [11:0] FLASH_CTL_HI = 12'hFFB;
  // Sequencer states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_CTL = 10'h002,
    ST_PC_HI = 10'h004,
    ST_PC_LO = 10'h008,
    ST_ADR_HI = 10'h010,
    ST_ADR_LO = 10'h020,
    ST_SIZE = 10'h040,
    ST_DATA = 10'h080,
    ST_TX_HI = 10'h100,
    ST_TX_LO = 10'h200
  } dci_state_t;
  // One register-file write
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } dci_rf_wr_t;
endpackage

// ===== dci_tx_sink.sv
// Far-side model: serialiser that takes response bytes.
// Assumes the tx handshake is sampled on rising clk edges.
`timescale 1ns/1ps
////////////////////////////////////////
module dci_tx_sink (
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] q[$]; // Bytes taken, in order
  // Stall holds back the serialiser, as a slow link would
  assign tx_ready = !stall;
  // Take one byte per handshake edge
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      q.push_back(tx_data);
  end
endmodule // dci_tx_sink

// ===== testbench.sv
// Self-checking bench for the debug command interpreter.
// Assumes dci_pkg, dci_debug_cmd and dci_tx_sink are compiled first.
`timescale 1ns/1ps
////////////////////////////////////////
module testbench;
  logic clk = 0, rstn = 0, rx_valid = 0, stall = 0, prot_n = 1;
  logic [7:0] rx_data = 8'h00;
  logic [15:0] cnt = 16'h1234, ip = 16'hABCD;
  logic rx_ready, tx_valid, tx_ready, pc_wr, rf_we, halt;
  logic [7:0] tx_data, ctl;
  logic [15:0] pc_data, pc_last;
  dci_pkg::dci_rf_wr_t rf_wr, rf_last;
  int n_fail = 0, total_checks = 0, cyc = 0, pc_n = 0, rf_n = 0;
  initial forever #2 clk = ~clk;
  dci_debug_cmd dci_debug_cmd_inst (.clk(clk), .rstn(rstn), .rx_valid(rx_valid),
    .rx_ready_q(rx_ready), .rx_data(rx_data), .tx_valid_q(tx_valid),
    .tx_ready(tx_ready), .tx_data_q(tx_data), .run_cycle_counter(cnt),
    .read_protect_option(prot_n), .instruction_pointer(ip),
    .debugger_control_reg(ctl), .halt_for_debug_flag(halt), .pc_wr_q(pc_wr),
    .pc_data_q(pc_data), .rf_we_q(rf_we), .rf_wr_q(rf_wr));
  dci_tx_sink dci_tx_sink_inst (.clk(clk), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  ////////////////////////////////////////
  // Pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge clk)
  begin
    if (pc_wr === 1'b1)
    begin
      pc_n++;
      pc_last = pc_data;
    end
    if (rf_we === 1'b1)
    begin
      rf_n++;
      rf_last = rf_wr;
    end
  end
  // Hang guard: whole run needs under 5000 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Hold byte until the edge that takes it; valid stays up
  task automatic send(input logic [7:0] b);
    rx_valid = 1'b1;
    rx_data = b;
    while (rx_ready !== 1'b1) @(posedge clk) #1;
    @(posedge clk) #1;
  endtask
  task automatic idle(input int n);
    rx_valid = 1'b0;
    repeat (n) @(posedge clk) #1;
  endtask
  // Wait, bounded, for n response bytes and compare them
  task automatic resp(input logic [15:0] exp, input int n);
    logic [7:0] hi;
    repeat (100) if (dci_tx_sink_inst.q.size() < n) @(posedge clk) #1;
    chk(dci_tx_sink_inst.q.size(), n);
    hi = (n == 2) ? dci_tx_sink_inst.q.pop_front() : 8'h00;
    chk({hi, dci_tx_sink_inst.q.pop_front()}, exp);
  endtask
  task automatic wctl(input logic [7:0] v);
    send(8'h04);
    send(v);
    idle(2);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp, input int n);
    send(c);
    idle(1);
    resp(exp, n);
  endtask
  // Register-file write of n bytes 40h, 41h, ...
  task automatic wreg(input logic [11:0] a, input logic [7:0] sz, input int n);
    send(8'h08);
    send({4'h0, a[11:8]});
    send(a[7:0]);
    send(sz);
    for (int i = 0; i < n; i++) send(8'(i) + 8'h40);
    idle(3);
  endtask
  ////////////////////////////////////////
  task automatic t_ctl;
    wctl(8'hA5);
    rd(8'h05, 16'h00A5, 1);
    chk(halt, 1'b1);
    wctl(8'h25);
    chk(ctl, 8'h25);
    send(8'h55);
    rd(8'h05, 16'h0025, 1);
    chk(ctl, 8'h25);
    $display("t_ctl done");
  endtask
  // Counter read with the serialiser stalled at first
  task automatic t_cnt;
    stall = 1'b1;
    send(8'h03);
    chk(rx_ready, 1'b0);
    idle(6);
    chk(rx_ready, 1'b1);
    chk(dci_tx_sink_inst.q.size(), 0);
    stall = 1'b0;
    resp(16'h1234, 2);
    $display("t_cnt done");
  endtask
  task automatic t_pc;
    wctl(8'h80);
    rd(8'h07, 16'hABCD, 2);
    send(8'h06);
    send(8'h5A);
    send(8'hC3);
    idle(3);
    chk(pc_n, 1);
    chk(pc_last, 16'h5AC3);
    wctl(8'h00);
    rd(8'h07, 16'hFFFF, 2);
    send(8'h06);
    send(8'h12);
    send(8'h34);
    idle(3);
    chk(pc_n, 1);
    $display("t_pc done");
  endtask
  task automatic t_reg;
    wctl(8'h80);
    wreg(12'h123, 8'h02, 2);
    chk(rf_n, 2);
    chk(rf_last, 20'h12441);
    wreg(12'h200, 8'h00, 256);
    chk(rf_n, 258);
    chk(rf_last.addr, 12'h2FF);
    wctl(8'h00);
    wreg(12'h123, 8'h01, 1);
    chk(rf_n, 258);
    rd(8'h05, 16'h0000, 1);
    prot_n = 1'b0;
    wctl(8'h80);
    wctl(8'h00);
    chk(halt, 1'b1);
    wreg(12'hFF8, 8'h02, 2);
    chk(rf_last, 20'hFF941);
    wreg(12'h123, 8'h01, 1);
    chk(rf_n, 260);
    rd(8'h07, 16'hFFFF, 2);
    $display("t_reg done");
  endtask
  // Queue 32 response bytes while stalled, then drain them
  task automatic t_fifo;
    stall = 1'b1;
    repeat (16) send(8'h03);
    idle(4);
    chk(tx_valid, 1'b1);
    stall = 1'b0;
    repeat (16) resp(16'h1234, 2);
    $display("t_fifo done");
  endtask
  ////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk) #1;
    t_ctl();
    t_cnt();
    t_pc();
    t_reg();
    t_fifo();
    tally_and_finish();
  end
endmodule // testbench
